// file: rtl/mxc_ctrl.sv
// Control, register file and exponent sequencer of the modular arithmetic unit
//
// Summary of operation
// - Optimized mode skips multiply on zero bits
// - Optimized-calculation bit resets to zero
// - Skip leading zeros, then multiply every bit unless optimized
// - Word size 1..2048 bits bounds operands
// - Oversized operands give no error status
// - Operands zero-padded; ignore beyond 64-bit block
// - Temporary and result segments hold intermediates
// - Segment b is scratch for square-multiply, exponent
// - Control register writable only while idle
// - Busy write to control or word size sets error, aborts, clears busy
// - Memory read while idle raises no error
// - All fields reset on every reset kind
// - Invalid word size refuses start
// - Done flag set on finish or error
// - Modulus in instance 5, exponent instance 4
// - Operand memory starts at offset 0x0100
`default_nettype none

module mxc_ctrl
	import mxc_pkg::*;
#(
	parameter int unsigned STEP_CYC = STEP_CYCLES  // Cycles per square or multiply
) (
	// Clock and resets
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset,
	input  wire logic        i_soft_reset,  // Synchronous peripheral reset
	// Peripheral register bus
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Status and step strobes
	output logic             o_irq,
	output logic             o_busy,
	output logic             o_step_square,
	output logic             o_step_multiply
);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic [11:0] mem_ofs;        // Byte offset inside memory window
	logic        hit_gc;         // Global control selected
	logic        hit_mc;         // Operation control selected
	logic        hit_ws;         // Word size selected
	logic        hit_cnt;        // Step counters selected
	logic        hit_mem;        // Operand memory selected
	logic        wr_fire;        // Write completes this cycle
	logic        rd_phase;       // First access cycle, data being gathered
	logic        busy_wr;        // Forbidden write while running
	logic        ws_ok;          // Word size in legal range
	logic        eng_finish;     // Sequencer reached the end
	logic [31:0] rd_mux;         // Read data before the output flop
	logic [31:0] mem_rdata;      // Memory read data
	logic [8:0]  mem_addr;       // Memory address after arbitration
	logic [8:0]  eng_addr;       // Sequencer exponent fetch address

	assign mem_ofs  = i_paddr - MEM_BASE;
	assign hit_gc   = (i_paddr == OFS_GLOBAL_CTRL);
	assign hit_mc   = (i_paddr == OFS_MODEXP_CTRL);
	assign hit_ws   = (i_paddr == OFS_WORD_SIZE);
	assign hit_cnt  = (i_paddr == OFS_STEP_COUNT);
	assign hit_mem  = (i_paddr >= MEM_BASE) && (i_paddr <= MEM_LAST);
	assign wr_fire  = i_psel & i_penable & i_pwrite & o_pready;
	assign rd_phase = i_psel & i_penable & ~o_pready;

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic        start_q;        // Start/busy bit
	logic [2:0]  op_q;           // Selected operation
	logic        ocal_q;         // Optimized calculation enable
	logic        err_q;          // Error status
	logic [15:0] seg_q;          // Segment assignment fields, stored only
	logic [11:0] ws_q;           // word_size_bits
	logic        irq_en_q;       // done_irq_enable
	logic        done_q;         // arith_done_flag
	logic        start_req;      // Legal start request

	assign ws_ok     = (ws_q != WS_RESET) && (ws_q <= WS_MAX);
	assign busy_wr   = wr_fire & (hit_mc | hit_ws) & start_q;
	assign start_req = wr_fire & hit_mc & ~start_q & i_pwdata[MC_START_BIT]
		& ws_ok & (i_pwdata[MC_OP_LSB+:3] <= OP_SUB);

	// Operation fields change only while idle
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			op_q   <= OP_RESET;
			ocal_q <= OCAL_RESET;
			seg_q  <= SEG_RESET;
		end
		else if (i_soft_reset)
		begin
			op_q   <= OP_RESET;
			ocal_q <= OCAL_RESET;
			seg_q  <= SEG_RESET;
		end
		else if (wr_fire & hit_mc & ~start_q)
		begin
			op_q   <= i_pwdata[MC_OP_LSB+:3];
			ocal_q <= i_pwdata[MC_OCAL_BIT];
			seg_q  <= i_pwdata[MC_SEG_LSB+:16];
		end
	end

	// Start/busy: abort first, then finish, then a legal start
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
			start_q <= 1'b0;
		else if (i_soft_reset)
			start_q <= 1'b0;
		else if (busy_wr)
			start_q <= 1'b0;
		else if (eng_finish)
			start_q <= 1'b0;
		else if (start_req)
			start_q <= 1'b1;
	end

	// Error status: a busy write sets it and wins over a clear by zero
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
			err_q <= 1'b0;
		else if (i_soft_reset)
			err_q <= 1'b0;
		else if (busy_wr)
			err_q <= 1'b1;
		else if (wr_fire & hit_mc & ~i_pwdata[MC_ERR_BIT])
			err_q <= 1'b0;
	end

	// Word size, ignored while busy since that write aborts instead
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
			ws_q <= WS_RESET;
		else if (i_soft_reset)
			ws_q <= WS_RESET;
		else if (wr_fire & hit_ws & ~start_q)
			ws_q <= i_pwdata[11:0];
	end

	// Done flag and its interrupt enable; a set beats a clear by zero
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			done_q   <= 1'b0;
			irq_en_q <= 1'b0;
		end
		else if (i_soft_reset)
		begin
			done_q   <= 1'b0;
			irq_en_q <= 1'b0;
		end
		else
		begin
			if (eng_finish | busy_wr)
				done_q <= 1'b1;
			else if (wr_fire & hit_gc & ~i_pwdata[GC_DONE_BIT])
				done_q <= 1'b0;
			if (wr_fire & hit_gc)
				irq_en_q <= i_pwdata[GC_IRQ_EN_BIT];
		end
	end

	// ----------------------------------------
	// Exponent sequencer
	// ----------------------------------------
	mxc_state_t  state_q;        // Sequencer state
	logic [11:0] bit_idx_q;      // Exponent bit under work
	logic        lead_q;         // Still skipping leading zeros
	logic        cur_bit_q;      // Value of the current exponent bit
	logic [7:0]  step_cnt_q;     // Cycles spent in the current step
	logic [11:0] sq_cnt_q;       // Squares done this operation
	logic [11:0] mul_cnt_q;      // Multiplies done this operation
	logic        step_end;       // Current step completes
	logic        exp_bit;        // Fetched exponent bit
	logic        is_exp;         // Exponentiation selected

	assign step_end   = (step_cnt_q == 8'(STEP_CYC - 1));
	assign exp_bit    = mem_rdata[bit_idx_q[4:0]];
	assign is_exp     = (op_q == OP_EXP);
	assign eng_finish = (state_q == ST_FINISH);
	assign eng_addr   = EXP_WORD_BASE + {3'h0, bit_idx_q[10:5]};

	// Operand values are not checked against the word size here
	// A wrong operand just yields a wrong result with no error status
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			state_q    <= ST_IDLE;
			bit_idx_q  <= 12'h000;
			lead_q     <= 1'b0;
			cur_bit_q  <= 1'b0;
			step_cnt_q <= 8'h00;
			sq_cnt_q   <= 12'h000;
			mul_cnt_q  <= 12'h000;
		end
		else if (i_soft_reset | ~start_q)
		begin
			// Abort or reset drops any step in flight; counts survive an abort, soft reset clears them
			state_q    <= ST_IDLE;
			step_cnt_q <= 8'h00;
			if (i_soft_reset)
			begin
				sq_cnt_q  <= 12'h000;
				mul_cnt_q <= 12'h000;
			end
		end
		else
		begin
			step_cnt_q <= step_end ? 8'h00 : step_cnt_q + 8'h01;
			case (state_q)
				ST_IDLE:
				begin
					sq_cnt_q   <= 12'h000;
					mul_cnt_q  <= 12'h000;
					step_cnt_q <= 8'h00;
					bit_idx_q  <= ws_q - 12'h001;
					lead_q     <= 1'b1;
					case (op_q)
						OP_EXP:   state_q <= ST_FETCH;
						OP_SQR:   state_q <= ST_SQUARE;
						OP_SQMUL: state_q <= ST_SQUARE;
						OP_MUL:   state_q <= ST_MULT;
						default:  state_q <= ST_ADDSUB;
					endcase
				end
				ST_FETCH:
					state_q <= ST_EVAL;  // Read data valid next cycle
				ST_EVAL:
				begin
					step_cnt_q <= 8'h00;
					if (lead_q & ~exp_bit)
					begin
						// Leading zero: neither square nor multiply
						state_q   <= (bit_idx_q == 12'h000) ? ST_FINISH : ST_FETCH;
						bit_idx_q <= bit_idx_q - 12'h001;
					end
					else
					begin
						lead_q    <= 1'b0;
						cur_bit_q <= exp_bit;
						state_q   <= ST_SQUARE;
					end
				end
				ST_SQUARE:
				begin
					// Result and temporary segments hold the round value
					if (step_end)
					begin
						sq_cnt_q <= sq_cnt_q + 12'h001;
						if (is_exp & ocal_q & ~cur_bit_q)
						begin
							// Optimized: zero bit gets the square only
							state_q   <= (bit_idx_q == 12'h000) ? ST_FINISH : ST_FETCH;
							bit_idx_q <= bit_idx_q - 12'h001;
						end
						else if (is_exp | (op_q == OP_SQMUL))
							state_q <= ST_MULT;
						else
							state_q <= ST_FINISH;
					end
				end
				ST_MULT:
				begin
					// Segment b is overwritten as scratch in these rounds
					if (step_end)
					begin
						mul_cnt_q <= mul_cnt_q + 12'h001;
						if (is_exp & (bit_idx_q != 12'h000))
						begin
							state_q   <= ST_FETCH;
							bit_idx_q <= bit_idx_q - 12'h001;
						end
						else
							state_q <= ST_FINISH;
					end
				end
				ST_ADDSUB:
					if (step_end)
						state_q <= ST_FINISH;
				ST_FINISH:
					state_q <= ST_IDLE;  // start_q drops on this edge
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Operand memory
	// ----------------------------------------
	// The sequencer owns the port while busy; host reads then see its data
	assign mem_addr = (state_q != ST_IDLE) ? eng_addr : mem_ofs[10:2];

	mxc_opmem #(
		.DEPTH (MEM_WORDS),
		.AW    (MEM_AW),
		.DW    (32)
	) u_opmem (
		.i_sys_clk (i_sys_clk),
		.i_wr_en   (wr_fire & hit_mem & ~start_q),
		.i_addr    (mem_addr),
		.i_wdata   (i_pwdata),
		.o_rdata   (mem_rdata)
	);

	// ----------------------------------------
	// Read mux and bus answer
	// ----------------------------------------
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (hit_gc)
		begin
			rd_mux[GC_IRQ_EN_BIT] = irq_en_q;
			rd_mux[GC_DONE_BIT]   = done_q;
			rd_mux[GC_READY_BIT]  = 1'b1;
		end
		else if (hit_mc)
			rd_mux = {8'h00, seg_q, err_q, 2'b00, ocal_q, op_q, start_q};
		else if (hit_ws)
			rd_mux[11:0] = ws_q;
		else if (hit_cnt)
			rd_mux = {4'h0, mul_cnt_q, 4'h0, sq_cnt_q};
		else if (hit_mem)
			rd_mux = mem_rdata;
	end

	// One wait state lets the memory read settle before the answer
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end
		else
		begin
			o_pready  <= rd_phase;
			o_pslverr <= rd_phase & ~(hit_gc | hit_mc | hit_ws | hit_cnt | hit_mem);
			o_prdata  <= rd_phase ? rd_mux : 32'h0000_0000;
		end
	end

	// Status outputs
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_irq           <= 1'b0;
			o_busy          <= 1'b0;
			o_step_square   <= 1'b0;
			o_step_multiply <= 1'b0;
		end
		else
		begin
			o_irq           <= done_q & irq_en_q;
			o_busy          <= start_q;
			o_step_square   <= start_q & (state_q == ST_SQUARE) & step_end;
			o_step_multiply <= start_q & (state_q == ST_MULT) & step_end;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);

	property p_opt_skip;
		(state_q == ST_SQUARE) && step_end && start_q && is_exp && ocal_q && !cur_bit_q |=> state_q != ST_MULT;
	endproperty
	a_opt_skip: assert property (p_opt_skip) else $error("multiply on zero bit in optimized mode");

	property p_ocal_reset;
		i_soft_reset |=> !ocal_q && !start_q && ws_q == WS_RESET;
	endproperty
	a_ocal_reset: assert property (p_ocal_reset) else $error("fields not cleared by soft reset");

	property p_const_work;
		(state_q == ST_SQUARE) && step_end && start_q && is_exp && !ocal_q |=> state_q == ST_MULT;
	endproperty
	a_const_work: assert property (p_const_work) else $error("multiply skipped in constant-work mode");

	property p_lead_skip;
		(state_q == ST_EVAL) && start_q && lead_q && !exp_bit |=> state_q inside {ST_FETCH, ST_FINISH, ST_IDLE};
	endproperty
	a_lead_skip: assert property (p_lead_skip) else $error("leading zero bit was worked");

	property p_busy_write;
		busy_wr |=> !start_q && err_q && done_q ##1 state_q == ST_IDLE;
	endproperty
	a_busy_write: assert property (p_busy_write) else $error("busy write did not abort");

	property p_idle_only;
		wr_fire && hit_mc && start_q |=> $stable(ocal_q) && $stable(op_q);
	endproperty
	a_idle_only: assert property (p_idle_only) else $error("control changed while busy");

	property p_bad_size;
		wr_fire && hit_mc && !start_q && !ws_ok |=> !start_q;
	endproperty
	a_bad_size: assert property (p_bad_size) else $error("start taken with invalid word size");

	property p_finish;
		eng_finish && !i_soft_reset |=> !start_q && done_q;
	endproperty
	a_finish: assert property (p_finish) else $error("finish did not clear busy or set done");

	property p_start;
		$rose(start_q) |-> !o_busy ##1 o_busy && state_q != ST_IDLE;
	endproperty
	a_start: assert property (p_start) else $error("start did not begin operation");

	property p_mem_noerr;
		rd_phase && hit_mem |=> o_pready && !o_pslverr;
	endproperty
	a_mem_noerr: assert property (p_mem_noerr) else $error("memory read flagged an error");

endmodule : mxc_ctrl

`default_nettype wire

// file: rtl/mxc_pkg.sv
// Constants and types shared by the modular exponentiation control block
`default_nettype none

package mxc_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFS_GLOBAL_CTRL  = 12'h000;  // crypto_global_control
	localparam logic [11:0] OFS_MODEXP_CTRL  = 12'h01C;  // modexp_control
	localparam logic [11:0] OFS_WORD_SIZE    = 12'h0D0;  // modexp_word_size
	localparam logic [11:0] OFS_STEP_COUNT   = 12'h0D8;  // square and multiply counts
	localparam logic [11:0] MEM_BASE         = 12'h100;  // operand memory window start
	localparam logic [11:0] MEM_LAST         = 12'h6FF;  // operand memory window end

	// ----------------------------------------
	// Operand memory geometry (32-bit words)
	// ----------------------------------------
	localparam int unsigned MEM_WORDS        = 384;
	localparam int unsigned MEM_AW           = 9;
	localparam logic [8:0]  EXP_WORD_BASE    = 9'h100;   // instance 4, byte 0x500
	localparam logic [8:0]  MOD_WORD_BASE    = 9'h140;   // instance 5, byte 0x600

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned GC_IRQ_EN_BIT    = 0;        // done_irq_enable
	localparam int unsigned GC_DONE_BIT      = 28;       // arith_done_flag
	localparam int unsigned GC_READY_BIT     = 30;       // block ready, reads one
	localparam int unsigned MC_START_BIT     = 0;        // start/busy
	localparam int unsigned MC_OP_LSB        = 1;        // operation select, 3 bits
	localparam int unsigned MC_OCAL_BIT      = 4;        // optimized calculation
	localparam int unsigned MC_ERR_BIT       = 7;        // error status
	localparam int unsigned MC_SEG_LSB       = 8;        // segment assignments, 16 bits
	localparam int unsigned CNT_MUL_LSB      = 16;       // multiply count field

	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic [2:0]  OP_RESET         = 3'h0;
	localparam logic        OCAL_RESET       = 1'b0;
	localparam logic [15:0] SEG_RESET        = 16'h0000;
	localparam logic [11:0] WS_RESET         = 12'h000;
	localparam logic [11:0] WS_MAX           = 12'h800;  // 2048 bits

	// ----------------------------------------
	// Operation codes
	// ----------------------------------------
	localparam logic [2:0]  OP_EXP           = 3'h0;
	localparam logic [2:0]  OP_SQR           = 3'h1;
	localparam logic [2:0]  OP_MUL           = 3'h2;
	localparam logic [2:0]  OP_SQMUL         = 3'h3;
	localparam logic [2:0]  OP_ADD           = 3'h4;
	localparam logic [2:0]  OP_SUB           = 3'h5;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS    = 4;
	localparam int unsigned STEP_TIME_NS     = 16;       // least time per arithmetic step
	localparam int unsigned STEP_CYCLES      = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Engine sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_EVAL,
		ST_SQUARE,
		ST_MULT,
		ST_ADDSUB,
		ST_FINISH
	} mxc_state_t;

endpackage : mxc_pkg

`default_nettype wire

// file: rtl/mxc_opmem.sv
// Single-port operand memory with registered read data
`default_nettype none

module mxc_opmem #(
	parameter int unsigned DEPTH = 384,
	parameter int unsigned AW    = 9,
	parameter int unsigned DW    = 32
) (
	// Clock
	input  wire logic          i_sys_clk,
	// Access port
	input  wire logic          i_wr_en,
	input  wire logic [AW-1:0] i_addr,
	input  wire logic [DW-1:0] i_wdata,
	output logic      [DW-1:0] o_rdata
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [DW-1:0] mem_q [DEPTH];  // No reset: operand contents are software's

	// Write and registered read share one address
	always_ff @(posedge i_sys_clk)
	begin
		if (i_wr_en)
		begin
			mem_q[i_addr] <= i_wdata;
		end
		o_rdata <= mem_q[i_addr];
	end

endmodule : mxc_opmem

`default_nettype wire

// file: test/mxc_host.sv
// Host processor model on the register bus of the modular exponentiation unit
`default_nettype none

module mxc_host
	import mxc_pkg::*;
(
	// Clock
	input  wire logic        i_sys_clk,
	// Bus answer
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr,
	// Bus request
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [11:0] o_paddr,
	output logic      [31:0] o_pwdata
);
	timeunit 1ns;
	timeprecision 100ps;

	int n_stalls;  // Accesses that never saw ready

	// Idle bus at time zero
	initial
	begin
		n_stalls  = 0;
		o_psel    = 1'b0;
		o_penable = 1'b0;
		o_pwrite  = 1'b0;
		o_paddr   = 12'h000;
		o_pwdata  = 32'h0000_0000;
	end

	// One access: setup, access, held until ready is sampled high
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(negedge i_sys_clk);
		o_psel   = 1'b1;
		o_pwrite = wr;
		o_paddr  = a;
		o_pwdata = d;
		@(negedge i_sys_clk);
		o_penable = 1'b1;
		@(posedge i_sys_clk);
		while (i_pready !== 1'b1 && n < 16)
		begin
			@(posedge i_sys_clk);
			n++;
		end
		// A missing ready is a failure, counted at the verdict
		if (i_pready !== 1'b1)
			n_stalls++;
		q = i_prdata;
		e = i_pslverr;
		@(negedge i_sys_clk);
		// Released address and data show the inverse, never a stale value
		o_psel    = 1'b0;
		o_penable = 1'b0;
		o_paddr   = ~o_paddr;
		o_pwdata  = ~o_pwdata;
	endtask : xfer

	// Operands for one exponentiation; only called while the unit is idle
	task load_exp(input int unsigned ws, input logic [31:0] e);
		logic [31:0] q;
		logic        s;
		xfer(1'b1, MEM_BASE, 32'h0000_0001, q, s);
		xfer(1'b1, MEM_BASE + 12'h004, 32'h0000_0000, q, s);
		xfer(1'b1, 12'h500, e, q, s);
		xfer(1'b1, 12'h504, 32'h0000_0000, q, s);
		// Beyond the 64-bit block anything may stand
		xfer(1'b1, 12'h508, 32'hFFFF_FFFF, q, s);
		xfer(1'b1, 12'h600, 32'h1 << (ws - 1), q, s);
		xfer(1'b1, 12'h604, 32'h0000_0000, q, s);
	endtask : load_exp

endmodule : mxc_host

`default_nettype wire

// file: test/tb.sv
// Self-checking testbench of the modular exponentiation control block
`default_nettype none

module tb
	import mxc_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        sys_clk;     // 250 MHz
	logic        reset;       // Async, active high
	logic        soft_reset;  // Sync peripheral reset
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        busy;
	logic        step_sq;
	logic        step_mul;
	int          n_errors;
	int          tests_run;
	int          n_sq;        // Square pulses seen
	int          n_mul;       // Multiply pulses seen

	// Short steps keep the run brief; counts do not depend on it
	mxc_ctrl #(.STEP_CYC(1)) mxc_ctrl_i (
		.i_sys_clk(sys_clk), .i_reset(reset), .i_soft_reset(soft_reset),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_irq(irq), .o_busy(busy), .o_step_square(step_sq), .o_step_multiply(step_mul)
	);

	mxc_host mxc_host_i (
		.i_sys_clk(sys_clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
		.o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata)
	);

	// Clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Step pulse counters
	always @(posedge sys_clk)
	begin
		if (step_sq === 1'b1)
			n_sq++;
		if (step_mul === 1'b1)
			n_mul++;
	end

	// ----------------------------------------
	// Compare and bus helpers
	// ----------------------------------------
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task chk_flag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_flag

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        s;
		mxc_host_i.xfer(1'b1, a, d, q, s);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
		logic [31:0] q;
		logic        s;
		mxc_host_i.xfer(1'b0, a, 32'h0000_0000, q, s);
		chk_word(q, exp);
		chk_flag(s, eerr);
	endtask : rd

	// Bounded wait until the unit is idle again
	task wait_idle();
		int n;
		n = 0;
		repeat (2) @(posedge sys_clk);
		while (busy !== 1'b0 && n < 20000)
		begin
			@(posedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
		chk_flag(busy, 1'b0);
	endtask : wait_idle

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset();
		logic [31:0] q;
		logic        s;
		rd(OFS_MODEXP_CTRL, 32'h0000_0000, 1'b0);
		rd(OFS_WORD_SIZE, 32'h0000_0000, 1'b0);
		rd(OFS_GLOBAL_CTRL, 32'h4000_0000, 1'b0);
		rd(12'h0D4, 32'h0000_0000, 1'b1);
		// Idle memory reads: data is unreliable, only the error matters
		mxc_host_i.xfer(1'b0, MEM_BASE, 32'h0, q, s);
		chk_flag(s, 1'b0);
		mxc_host_i.xfer(1'b0, MEM_LAST - 12'h003, 32'h0, q, s);
		chk_flag(s, 1'b0);
	endtask : t_reset

	task t_op(input logic [2:0] op, input logic oc, input logic [11:0] ws, input logic [31:0] e,
		input logic [11:0] sq, input logic [11:0] mul);
		mxc_host_i.load_exp(ws, e);
		wr(OFS_WORD_SIZE, {20'h0, ws});
		n_sq = 0;
		n_mul = 0;
		wr(OFS_MODEXP_CTRL, {27'h0, oc, op, 1'b1});
		wait_idle();
		chk_word(n_sq, {20'h0, sq});
		chk_word(n_mul, {20'h0, mul});
		chk_flag(irq, 1'b0);
		rd(OFS_STEP_COUNT, {4'h0, mul, 4'h0, sq}, 1'b0);
		rd(OFS_MODEXP_CTRL, {27'h0, oc, op, 1'b0}, 1'b0);
		rd(OFS_GLOBAL_CTRL, 32'h5000_0000, 1'b0);
		wr(OFS_GLOBAL_CTRL, 32'h0000_0000);
		rd(OFS_GLOBAL_CTRL, 32'h4000_0000, 1'b0);
	endtask : t_op

	// Writes while busy abort, flag error and are not stored
	task t_abort(input logic [11:0] a, input logic [31:0] d);
		mxc_host_i.load_exp(32, 32'hFFFF_FFFF);
		wr(OFS_GLOBAL_CTRL, 32'h0000_0001);
		wr(OFS_WORD_SIZE, 32'h0000_0020);
		wr(OFS_MODEXP_CTRL, 32'h0000_0001);
		@(negedge sys_clk);
		chk_flag(busy, 1'b1);
		wr(a, d);
		wait_idle();
		chk_flag(irq, 1'b1);
		rd(OFS_MODEXP_CTRL, 32'h0000_0080, 1'b0);
		rd(OFS_WORD_SIZE, 32'h0000_0020, 1'b0);
		rd(OFS_GLOBAL_CTRL, 32'h5000_0001, 1'b0);
		wr(OFS_MODEXP_CTRL, 32'h00A5_5A00);
		wr(OFS_GLOBAL_CTRL, 32'h0000_0000);
		rd(OFS_MODEXP_CTRL, 32'h00A5_5A00, 1'b0);
		chk_flag(irq, 1'b0);
	endtask : t_abort

	// Word size bounds, then a soft reset in mid-run
	task t_size();
		// Size zero, size too large, then a good size with an unknown operation
		for (int i = 0; i < 3; i++)
		begin
			wr(OFS_WORD_SIZE, (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'h0000_0801 : 32'h0000_0020);
			wr(OFS_MODEXP_CTRL, (i == 2) ? 32'h0000_000F : 32'h0000_0001);
			repeat (3) @(negedge sys_clk);
			chk_flag(busy, 1'b0);
			rd(OFS_MODEXP_CTRL, (i == 2) ? 32'h0000_000E : 32'h0000_0000, 1'b0);
		end
		wr(12'h5FC, 32'h8000_0000);
		wr(OFS_WORD_SIZE, {20'h0, WS_MAX});
		wr(OFS_MODEXP_CTRL, 32'h0000_0011);
		@(negedge sys_clk);
		chk_flag(busy, 1'b1);
		soft_reset = 1'b1;
		@(negedge sys_clk);
		soft_reset = 1'b0;
		rd(OFS_MODEXP_CTRL, 32'h0000_0000, 1'b0);
		rd(OFS_WORD_SIZE, 32'h0000_0000, 1'b0);
		chk_flag(busy, 1'b0);
	endtask : t_size

	// ----------------------------------------
	// Verdict, watchdog and main sequence
	// ----------------------------------------
	task close_out();
		n_errors = n_errors + mxc_host_i.n_stalls;
		if (n_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// Run needs under a thousand cycles; 50000 means a hang
	initial
	begin
		#200000;
		n_errors++;
		close_out();
	end

	initial
	begin
		n_errors = 0;
		tests_run = 0;
		n_sq = 0;
		n_mul = 0;
		reset = 1'b1;
		soft_reset = 1'b0;
		repeat (8) @(negedge sys_clk);
		reset = 1'b0;
		t_reset();
		t_op(OP_EXP, 1'b0, 12'h008, 32'h0000_0005, 12'h003, 12'h003);
		t_op(OP_EXP, 1'b1, 12'h008, 32'h0000_0005, 12'h003, 12'h002);
		t_op(OP_EXP, 1'b0, 12'h008, 32'h0000_0105, 12'h003, 12'h003);
		t_op(OP_EXP, 1'b0, 12'h001, 32'h0000_0001, 12'h001, 12'h001);
		t_op(OP_SQR, 1'b0, 12'h008, 32'h0000_0005, 12'h001, 12'h000);
		t_op(OP_MUL, 1'b0, 12'h008, 32'h0000_0005, 12'h000, 12'h001);
		t_op(OP_SQMUL, 1'b0, 12'h008, 32'h0000_0005, 12'h001, 12'h001);
		t_op(OP_ADD, 1'b0, 12'h008, 32'h0000_0005, 12'h000, 12'h000);
		t_op(OP_SUB, 1'b0, 12'h008, 32'h0000_0005, 12'h000, 12'h000);
		t_abort(OFS_MODEXP_CTRL, 32'h0000_0011);
		t_abort(OFS_WORD_SIZE, 32'h0000_0010);
		t_size();
		close_out();
	end

endmodule : tb

`default_nettype wire
